/* File: logic/osc_pkg.sv */
package osc_pkg;
    // register byte offsets on the control bus
    localparam logic [7:0] CTRL_ONE_OFS = 8'h00;
    localparam logic [7:0] FREQ_OFS = 8'h04;
    localparam logic [7:0] TUNE_OFS = 8'h08;
    localparam logic [7:0] ENABLE_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] CONV_SEL_OFS = 8'h14;
    // field positions
    localparam int NEW_SRC_LSB = 4;
    localparam int NEW_DIV_LSB = 0;
    localparam int CONV_MAN_BIT = 2;
    // reset values
    localparam logic [3:0] FREQ_RESET = 4'hF;
    localparam logic [5:0] TUNE_RESET = 6'h00;
    localparam logic [3:0] NEW_DIV_RESET = 4'h0;
    // oscillator source codes
    localparam logic [2:0] SRC_HF_64M = 3'h0;
    localparam logic [2:0] SRC_LF = 3'h5;
    localparam logic [2:0] SRC_HF_1M = 3'h6;
    // tune extremes
    localparam logic [5:0] TUNE_MAX = 6'h1F;
    localparam logic [5:0] TUNE_MIN = 6'h20;
    // fixed rates in kHz, MF_LO_HZ in Hz
    localparam int LF_KHZ = 31;
    localparam int MF_HI_KHZ = 500;
    localparam int MF_LO_HZ = 31250;
    localparam int CONV_KHZ = 600;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // tune slew: cycles spent in SW_SLEW per step; with SW_DONE and SW_IDLE one step every 18 cycles
    localparam int SLEW_CYCLES = 16;
    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_SLEW = 3'b010,
        SW_DONE = 3'b100
    } slew_e;
endpackage : osc_pkg

/* File: logic/rate_div.sv */
`timescale 1ns/100ps
// programmable modulo counter producing a one-cycle tick
module rate_div (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // ratio, tick every ratio cycles
    input wire logic [9:0] ratio,
    output logic tick
);
    logic [9:0] cnt_reg;

    // count down, reload on terminal count; a new ratio takes effect at reload
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cnt_reg <= 10'h000;
            tick <= 1'b0;
        end else if (cnt_reg == 10'h000) begin
            cnt_reg <= ratio - 10'h001;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg - 10'h001;
            tick <= 1'b0;
        end
    end
endmodule : rate_div

/* File: logic/osc_sources.sv */
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module osc_sources (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // configuration strap
    input wire logic [2:0] RESET_OSC_SELECT,
    // axi4-lite write address
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // axi4-lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read address
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // axi4-lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // oscillator state
    output logic HF_RUN,
    output logic LF_RUN,
    output logic CONV_RUN,
    output logic [5:0] HF_TRIM,
    output logic [9:0] SYS_DIV,
    output logic [2:0] SYS_SRC,
    // derived clock ticks
    output logic MF_500K_TICK,
    output logic MF_31K_TICK
);
    logic [2:0] strap_s1_reg;
    logic [2:0] strap_s2_reg;
    logic strap_taken_reg;
    logic [2:0] new_src_reg;
    logic [3:0] new_div_reg;
    logic [3:0] hf_sel_reg;
    logic [5:0] tune_reg;
    logic [5:0] trim_reg;
    logic conv_man_reg;
    logic conv_sel_reg;
    logic [3:0] slew_cnt_reg;
    osc_pkg::slew_e slew_state_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_value;
    logic t500;
    logic t31;
    logic [9:0] r500;
    logic [9:0] r31;

    // system clock divider ratio, 2 to the power of the select, capped at 512
    function automatic logic [9:0] div_ratio(input logic [3:0] sel);
        logic [9:0] r;
        r = 10'h001;
        if (sel <= 4'h9) begin
            r = 10'(1 << sel);
        end else begin
            r = 10'h200;
        end
        return r;
    endfunction : div_ratio

    // oscillator rate in kHz for each frequency select code
    function automatic int hf_khz(input logic [3:0] sel);
        int k;
        k = 1000;
        case (sel)
            4'h0: k = 1000;
            4'h1: k = 2000;
            4'h2: k = 4000;
            4'h3: k = 8000;
            4'h4: k = 12000;
            4'h5: k = 16000;
            4'h6: k = 32000;
            4'h7: k = 48000;
            default: k = 64000;
        endcase
        return k;
    endfunction : hf_khz

    // mid-frequency ratios, model ticks at the scaled system clock
    function automatic logic [9:0] mf_ratio(input logic [3:0] sel, input int out_hz);
        int q;
        q = (hf_khz(sel) * 1000) / (out_hz * 64);
        if (q < 1) begin
            q = 1;
        end
        return 10'(q);
    endfunction : mf_ratio

    assign r500 = mf_ratio(hf_sel_reg, osc_pkg::MF_HI_KHZ * 1000);
    assign r31 = mf_ratio(hf_sel_reg, osc_pkg::MF_LO_HZ);

    // strap synchroniser keeps running through reset, so it has settled when latched
    always_ff @(posedge CLK) begin
        strap_s1_reg <= RESET_OSC_SELECT;
        strap_s2_reg <= strap_s1_reg;
    end

    // write channel capture, address and data in either order
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= AWADDR;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    assign wr_fire = aw_hold_reg && w_hold_reg && !BVALID;
    assign wr_ok = (awaddr_reg == osc_pkg::CTRL_ONE_OFS) || (awaddr_reg == osc_pkg::FREQ_OFS)
        || (awaddr_reg == osc_pkg::TUNE_OFS) || (awaddr_reg == osc_pkg::ENABLE_OFS)
        || (awaddr_reg == osc_pkg::CONV_SEL_OFS) || (awaddr_reg == osc_pkg::STATUS_OFS);

    // ready and response; one write outstanding at a time
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= osc_pkg::RESP_OKAY;
        end else begin
            AWREADY <= !aw_hold_reg && !(AWVALID && AWREADY) && !BVALID;
            WREADY <= !w_hold_reg && !(WVALID && WREADY) && !BVALID;
            if (wr_fire) begin
                BVALID <= 1'b1;
                BRESP <= wr_ok ? osc_pkg::RESP_OKAY : osc_pkg::RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // control registers; the strap loads the source once after reset release
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            strap_taken_reg <= 1'b0;
            new_src_reg <= osc_pkg::SRC_HF_64M;
            new_div_reg <= osc_pkg::NEW_DIV_RESET;
            hf_sel_reg <= osc_pkg::FREQ_RESET;
            tune_reg <= osc_pkg::TUNE_RESET;
            conv_man_reg <= 1'b0;
            conv_sel_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            new_src_reg <= strap_s2_reg;
        end else if (wr_fire && wstrb_reg[0]) begin
            case (awaddr_reg)
                osc_pkg::CTRL_ONE_OFS: begin
                    new_src_reg <= wdata_reg[osc_pkg::NEW_SRC_LSB +: 3];
                    new_div_reg <= wdata_reg[osc_pkg::NEW_DIV_LSB +: 4];
                end
                osc_pkg::FREQ_OFS: hf_sel_reg <= wdata_reg[3:0];
                osc_pkg::TUNE_OFS: tune_reg <= wdata_reg[5:0];
                osc_pkg::ENABLE_OFS: conv_man_reg <= wdata_reg[osc_pkg::CONV_MAN_BIT];
                osc_pkg::CONV_SEL_OFS: conv_sel_reg <= wdata_reg[0];
                default: begin
                end
            endcase
        end
    end

    // trim slews one step at a time toward tune; signed compare, nothing reports arrival
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            trim_reg <= osc_pkg::TUNE_RESET;
            slew_cnt_reg <= 4'h0;
            slew_state_reg <= osc_pkg::SW_IDLE;
        end else begin
            case (slew_state_reg)
                osc_pkg::SW_IDLE: begin
                    if (trim_reg != tune_reg) begin
                        slew_state_reg <= osc_pkg::SW_SLEW;
                        slew_cnt_reg <= 4'(osc_pkg::SLEW_CYCLES - 1);
                    end
                end
                osc_pkg::SW_SLEW: begin
                    if (slew_cnt_reg != 4'h0) begin
                        slew_cnt_reg <= slew_cnt_reg - 4'h1;
                    end else begin
                        slew_state_reg <= osc_pkg::SW_DONE;
                        if ($signed(tune_reg) > $signed(trim_reg)) begin
                            trim_reg <= trim_reg + 6'h01;
                        end else if ($signed(tune_reg) < $signed(trim_reg)) begin
                            trim_reg <= trim_reg - 6'h01;
                        end
                    end
                end
                osc_pkg::SW_DONE: slew_state_reg <= osc_pkg::SW_IDLE;
                default: slew_state_reg <= osc_pkg::SW_IDLE;
            endcase
        end
    end

    // source enables; mid-frequency never reaches the system source
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            HF_RUN <= 1'b0;
            LF_RUN <= 1'b0;
            CONV_RUN <= 1'b0;
            SYS_SRC <= osc_pkg::SRC_HF_64M;
            SYS_DIV <= 10'h001;
            HF_TRIM <= osc_pkg::TUNE_RESET;
        end else begin
            HF_RUN <= (new_src_reg == osc_pkg::SRC_HF_64M) || (new_src_reg == osc_pkg::SRC_HF_1M);
            LF_RUN <= 1'b1; // always on for timers
            CONV_RUN <= conv_man_reg || conv_sel_reg;
            SYS_SRC <= new_src_reg;
            SYS_DIV <= div_ratio(new_div_reg);
            HF_TRIM <= trim_reg;
        end
    end

    rate_div u_mf500 (
        .CLK(CLK),
        .NRST(NRST),
        .ratio(r500),
        .tick(t500)
    );

    rate_div u_mf31 (
        .CLK(CLK),
        .NRST(NRST),
        .ratio(r31),
        .tick(t31)
    );

    // ticks registered to keep outputs flop-driven
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            MF_500K_TICK <= 1'b0;
            MF_31K_TICK <= 1'b0;
        end else begin
            MF_500K_TICK <= t500;
            MF_31K_TICK <= t31;
        end
    end

    // read mux; reserved bits zero
    always_comb begin
        rd_ok = 1'b1;
        rd_value = 32'h0000_0000;
        case (ARADDR)
            osc_pkg::CTRL_ONE_OFS: rd_value = {25'h0, new_src_reg, new_div_reg};
            osc_pkg::FREQ_OFS: rd_value = {28'h0, hf_sel_reg};
            osc_pkg::TUNE_OFS: rd_value = {26'h0, tune_reg};
            osc_pkg::ENABLE_OFS: rd_value = {29'h0, conv_man_reg, 2'h0};
            osc_pkg::STATUS_OFS: rd_value = {29'h0, CONV_RUN, LF_RUN, HF_RUN};
            osc_pkg::CONV_SEL_OFS: rd_value = {31'h0, conv_sel_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // read channel, one read outstanding
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= osc_pkg::RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA <= rd_value;
                RRESP <= rd_ok ? osc_pkg::RESP_OKAY : osc_pkg::RESP_SLVERR;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    strap_hf_a: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(strap_taken_reg) && (new_src_reg == osc_pkg::SRC_HF_1M) |=> HF_RUN)
        else $error("strap 110 did not start hf");
    conv_auto_a: assert property (@(posedge CLK) disable iff (!NRST)
        conv_sel_reg |=> CONV_RUN)
        else $error("converter osc not auto enabled");
    conv_man_a: assert property (@(posedge CLK) disable iff (!NRST)
        !conv_man_reg && !conv_sel_reg |=> !CONV_RUN)
        else $error("converter osc runs without enable");
    trim_step_a: assert property (@(posedge CLK) disable iff (!NRST)
        trim_reg != $past(trim_reg) |-> ((trim_reg - $past(trim_reg)) == 6'h01)
        || (($past(trim_reg) - trim_reg) == 6'h01))
        else $error("trim jumped more than one step");
    trim_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
        trim_reg == tune_reg |=> trim_reg == $past(tune_reg) || tune_reg != $past(tune_reg))
        else $error("trim moved while settled");
    lf_on_a: assert property (@(posedge CLK) disable iff (!NRST)
        strap_taken_reg |=> LF_RUN)
        else $error("low frequency osc stopped");
    div_max_a: assert property (@(posedge CLK) disable iff (!NRST)
        new_div_reg >= 4'h9 |=> SYS_DIV == 10'h200)
        else $error("divider not capped at 512");
    src_follow_a: assert property (@(posedge CLK) disable iff (!NRST)
        ##1 SYS_SRC == $past(new_src_reg))
        else $error("system source not following select");
    tick_gap_a: assert property (@(posedge CLK) disable iff (!NRST)
        t500 && r500 > 10'h001 |=> !t500)
        else $error("mid tick back to back");
    slew_c: cover property (@(posedge CLK) disable iff (!NRST)
        slew_state_reg == osc_pkg::SW_SLEW ##[1:40] trim_reg == osc_pkg::TUNE_MAX);
    wr_c: cover property (@(posedge CLK) disable iff (!NRST) BVALID && BREADY);
    rd_c: cover property (@(posedge CLK) disable iff (!NRST) RVALID && RREADY);
    conv_c: cover property (@(posedge CLK) disable iff (!NRST) $rose(CONV_RUN));
endmodule : osc_sources

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
    logic CLK, NRST;
    logic [2:0] RESET_OSC_SELECT;
    logic [7:0] AWADDR, ARADDR;
    logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    logic [31:0] WDATA, RDATA;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    logic HF_RUN, LF_RUN, CONV_RUN, MF_500K_TICK, MF_31K_TICK;
    logic [5:0] HF_TRIM;
    logic [9:0] SYS_DIV;
    logic [2:0] SYS_SRC;
    int mismatches, cmp_count;
    logic [1:0] rsp;
    logic [31:0] rd;
    logic [3:0] nd;
    logic [2:0] ns;
    logic [5:0] tv;

    osc_sources osc_sources_inst (
        .CLK(CLK), .NRST(NRST), .RESET_OSC_SELECT(RESET_OSC_SELECT),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .HF_RUN(HF_RUN), .LF_RUN(LF_RUN), .CONV_RUN(CONV_RUN), .HF_TRIM(HF_TRIM),
        .SYS_DIV(SYS_DIV), .SYS_SRC(SYS_SRC),
        .MF_500K_TICK(MF_500K_TICK), .MF_31K_TICK(MF_31K_TICK)
    );

    // 20 MHz system clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    function automatic logic [31:0] exp_div(input logic [3:0] n);
        return (n >= 4'h9) ? 32'h200 : (32'h1 << n);
    endfunction : exp_div

    function automatic logic [31:0] exp_hf(input logic [2:0] s);
        return {31'h0, (s == osc_pkg::SRC_HF_64M) || (s == osc_pkg::SRC_HF_1M)};
    endfunction : exp_hf

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // address and data offered together, each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge CLK);
            if (!aw_done && AWREADY === 1'b1) begin
                aw_done = 1'b1;
                AWVALID <= 1'b0;
            end
            if (!w_done && WREADY === 1'b1) begin
                w_done = 1'b1;
                WVALID <= 1'b0;
            end
        end
        do @(posedge CLK); while (BVALID !== 1'b1);
        r = BRESP;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
    endtask : axi_rd

    // count tick pulses; one-cycle pulses when the ratio is above one, steady high at ratio one
    task automatic tick_check(input bit single);
        int h5, h3, r5, r3;
        logic p5, p3;
        h5 = 0;
        h3 = 0;
        r5 = 0;
        r3 = 0;
        p5 = 1'b0;
        p3 = 1'b0;
        repeat (40) @(posedge CLK); // both dividers reload after a ratio change
        repeat (2100) begin
            @(posedge CLK);
            if (MF_500K_TICK === 1'b1) h5++;
            if (MF_500K_TICK === 1'b1 && !p5) r5++;
            if (MF_31K_TICK === 1'b1) h3++;
            if (MF_31K_TICK === 1'b1 && !p3) r3++;
            p5 = MF_500K_TICK;
            p3 = MF_31K_TICK;
        end
        chk(h5 >= 2, 1);
        chk(h3 >= 2, 1);
        chk(h5, single ? r5 : 2100);
        chk(h3, single ? r3 : 2100);
        if (single) begin
            chk((h5 + 32 >= 16 * h3) && (h5 <= 16 * h3 + 32), 1);
        end
    endtask : tick_check

    // watchdog: the whole sequence needs well under this span
    initial begin
        repeat (60000) @(posedge CLK);
        mismatches++;
        wrap_up();
    end

    initial begin
        NRST = 1'b0; RESET_OSC_SELECT = osc_pkg::SRC_HF_1M;
        AWADDR = 8'h00; AWVALID = 1'b0; WDATA = 32'h0; WSTRB = 4'h0; WVALID = 1'b0;
        BREADY = 1'b1; ARADDR = 8'h00; ARVALID = 1'b0; RREADY = 1'b1;
        mismatches = 0; cmp_count = 0;
        void'($urandom(96));
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge CLK);
        // strap selects the 1 MHz high-frequency source
        chk(SYS_SRC, osc_pkg::SRC_HF_1M);
        chk(HF_RUN, 1);
        chk(LF_RUN, 1);
        axi_rd(osc_pkg::FREQ_OFS, rd, rsp);
        chk(rd[3:0], osc_pkg::FREQ_RESET);
        axi_rd(osc_pkg::TUNE_OFS, rd, rsp);
        chk(rd[5:0], osc_pkg::TUNE_RESET);
        axi_rd(osc_pkg::STATUS_OFS, rd, rsp);
        chk(rd[2:0], 3'h3);
        tick_check(1'b1);
        // every source code and every divider code, random source partners for divider codes 8 to 15
        for (int i = 0; i < 16; i++) begin
            nd = i[3:0];
            ns = (i < 8) ? i[2:0] : 3'($urandom_range(7, 0));
            axi_wr(osc_pkg::CTRL_ONE_OFS, {25'h0, ns, nd}, 4'hF, rsp);
            repeat (3) @(posedge CLK);
            chk(rsp, osc_pkg::RESP_OKAY);
            chk(SYS_SRC, ns);
            chk(HF_RUN, exp_hf(ns));
            chk(SYS_DIV, exp_div(nd));
            chk(LF_RUN, 1);
        end
        // new frequency select, ticks must keep coming
        axi_wr(osc_pkg::FREQ_OFS, 32'h0, 4'hF, rsp);
        axi_rd(osc_pkg::FREQ_OFS, rd, rsp);
        chk(rd[3:0], 4'h0);
        tick_check(1'b0);
        // tune extremes then random values, each reached by slewing
        for (int i = 0; i < 5; i++) begin
            tv = (i == 0) ? osc_pkg::TUNE_MAX : (i == 1) ? osc_pkg::TUNE_MIN :
                 6'($urandom_range(63, 0));
            axi_wr(osc_pkg::TUNE_OFS, {26'h0, tv}, 4'hF, rsp);
            if (i < 2) begin
                chk(HF_TRIM !== tv, 1);
            end
            for (int n = 0; n < 1500 && HF_TRIM !== tv; n++) @(posedge CLK);
            chk(HF_TRIM, tv);
            chk(LF_RUN, 1);
            axi_rd(osc_pkg::TUNE_OFS, rd, rsp);
            chk(rd[5:0], tv);
        end
        // strobe low write is dropped but answered okay
        axi_wr(osc_pkg::TUNE_OFS, 32'h5, 4'h0, rsp);
        chk(rsp, osc_pkg::RESP_OKAY);
        axi_rd(osc_pkg::TUNE_OFS, rd, rsp);
        chk(rd[5:0], tv);
        // converter oscillator: manual enable, then auto enable by selection
        axi_wr(osc_pkg::ENABLE_OFS, 32'h4, 4'hF, rsp);
        repeat (3) @(posedge CLK);
        chk(CONV_RUN, 1);
        axi_rd(osc_pkg::STATUS_OFS, rd, rsp);
        chk(rd[2], 1'b1);
        axi_wr(osc_pkg::ENABLE_OFS, 32'h0, 4'hF, rsp);
        repeat (3) @(posedge CLK);
        chk(CONV_RUN, 0);
        axi_wr(osc_pkg::CONV_SEL_OFS, 32'h1, 4'hF, rsp);
        repeat (3) @(posedge CLK);
        chk(CONV_RUN, 1);
        axi_wr(osc_pkg::CONV_SEL_OFS, 32'h0, 4'hF, rsp);
        repeat (3) @(posedge CLK);
        chk(CONV_RUN, 0);
        // unmapped place is refused on both paths
        axi_wr(8'h40, 32'hFF, 4'hF, rsp);
        chk(rsp, osc_pkg::RESP_SLVERR);
        axi_rd(8'h40, rd, rsp);
        chk(rsp, osc_pkg::RESP_SLVERR);
        // second reset in mid-run, strap now on the low-frequency code
        NRST <= 1'b0;
        RESET_OSC_SELECT <= osc_pkg::SRC_LF;
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge CLK);
        chk(SYS_SRC, osc_pkg::SRC_LF);
        chk(HF_RUN, exp_hf(osc_pkg::SRC_LF));
        chk(LF_RUN, 1);
        chk(HF_TRIM, osc_pkg::TUNE_RESET);
        chk(CONV_RUN, 0);
        axi_rd(osc_pkg::TUNE_OFS, rd, rsp);
        chk(rd[5:0], osc_pkg::TUNE_RESET);
        wrap_up();
    end
endmodule : tb
